/* File: include/pcseq_pkg.sv */
// Constants and types for the program counter sequencer.
// Assumes a decoder that issues one sequencing command per instruction cycle.
//------------------------------------------------------------------------------
// Package
//------------------------------------------------------------------------------
package pcseq_pkg;

  localparam int PC_W        = 12;
  localparam int TARGET_W    = 10;
  localparam int DATA_W      = 8;
  localparam int INSTR_W     = 13;
  localparam int PAGE_WORDS  = 1024;
  localparam int STACK_DEPTH = 8;
  localparam logic [11:0] PC_RESET = 12'h000;

  // Status register page-select positions
  localparam int PAGE_HIGH_BIT = 6;
  localparam int PAGE_LOW_BIT  = 5;

  // AXI4-Lite register byte addresses
  localparam logic [7:0] ADDR_PC     = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_OPTION = 8'h08;
  localparam logic [7:0] ADDR_DEPTH  = 8'h0c;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Sequencing commands from the decoder
  typedef enum logic [2:0]
  {
    PCSEQ_OP_NEXT   = 3'h0,
    PCSEQ_OP_JUMP   = 3'h1,
    PCSEQ_OP_CALL   = 3'h2,
    PCSEQ_OP_RETURN = 3'h3,
    PCSEQ_OP_ADD    = 3'h4,
    PCSEQ_OP_WRITE  = 3'h5,
    PCSEQ_OP_NONE   = 3'h6
  } pcseq_op_t;

endpackage

/* File: logic/pcseq_stack.sv */
// Circular hardware return stack.
// Assumes the caller never pushes and pops in the same cycle.
`timescale 1ns/1ps
`default_nettype none

module pcseq_stack #(
  parameter int DEPTH = pcseq_pkg::STACK_DEPTH,
  parameter int W     = pcseq_pkg::PC_W
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         reset_n,
  // Control
  input  wire logic         push,
  input  wire logic         pop,
  input  wire logic [W-1:0] push_data,
  // State
  output logic      [W-1:0] top_data,
  output logic      [7:0]   fill_level
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0]  entry_ff [DEPTH];
  logic [PW-1:0] ptr_ff;
  logic [PW-1:0] nxt_ptr;
  logic [7:0]    cnt_ff;
  logic [7:0]    nxt_cnt;
  logic [PW-1:0] top_idx;

  // Top of stack sits one below the write pointer
  always_comb
  begin
    top_idx = (ptr_ff == '0) ? PW'(DEPTH - 1) : ptr_ff - 1'b1;
    top_data = entry_ff[top_idx];
    fill_level = cnt_ff;
  end

  // Pointer wraps, so overflow overwrites the oldest entry
  always_comb
  begin
    nxt_ptr = ptr_ff;
    nxt_cnt = cnt_ff;
    if (push)
    begin
      nxt_ptr = (ptr_ff == PW'(DEPTH - 1)) ? '0 : ptr_ff + 1'b1;
      if (cnt_ff != 8'(DEPTH))
        nxt_cnt = cnt_ff + 8'h01;
    end
    else if (pop)
    begin
      nxt_ptr = top_idx;
      if (cnt_ff != 8'h00)
        nxt_cnt = cnt_ff - 8'h01;
    end
  end

  // Entries have no reset; popping empty returns stale data by design
  always_ff @(posedge core_clk)
  begin
    if (push)
      entry_ff[ptr_ff] <= push_data;
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      ptr_ff <= '0;
      cnt_ff <= 8'h00;
    end
    else
    begin
      ptr_ff <= nxt_ptr;
      cnt_ff <= nxt_cnt;
    end
  end

endmodule

`default_nettype wire

/* File: logic/pcseq_top.sv */
// Program counter and return stack sequencer with AXI4-Lite registers.
// Assumes the decoder holds each command until cmd_ready is high.
//
// Our own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module pcseq_top #(
  parameter int STACK_DEPTH = pcseq_pkg::STACK_DEPTH
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // Decoder command
  input  wire logic        cmd_valid,
  input  wire logic [2:0]  cmd_op,
  input  wire logic [9:0]  cmd_target,
  input  wire logic [7:0]  cmd_data,
  output logic             cmd_ready,
  // Status register from the core
  input  wire logic [7:0]  status_flags_reg,
  // Program memory fetch
  output logic [11:0]      fetch_addr,
  output logic             fetch_valid,
  // AXI4-Lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  // AXI4-Lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp
);

  //----------------------------------------------------------------------------
  // Declarations
  //----------------------------------------------------------------------------
  typedef enum {PCSEQ_RUN, PCSEQ_STALL} pcseq_state_t;

  pcseq_state_t  state_ff;
  pcseq_state_t  nxt_state;
  logic [11:0]   pc_ff;
  logic [11:0]   nxt_pc;
  logic          fetch_valid_ff;
  logic          nxt_fetch_valid;
  logic          branch_cycle_option_ff;
  logic          nxt_branch_cycle_option;
  logic [1:0]    page_bits;
  logic          push;
  logic          pop;
  logic [11:0]   stack_top;
  logic [7:0]    stack_fill;
  logic          take;
  logic          writes_pc;

  // Write channel state
  logic          aw_hold_ff;
  logic          nxt_aw_hold;
  logic [7:0]    aw_addr_ff;
  logic [7:0]    nxt_aw_addr;
  logic          w_hold_ff;
  logic          nxt_w_hold;
  logic [31:0]   w_data_ff;
  logic [31:0]   nxt_w_data;
  logic [3:0]    w_strb_ff;
  logic [3:0]    nxt_w_strb;
  logic          bvalid_ff;
  logic          nxt_bvalid;
  logic [1:0]    bresp_ff;
  logic [1:0]    nxt_bresp;
  logic          sw_pc_we;
  logic [11:0]   sw_pc_val;

  // Read channel state
  logic          rvalid_ff;
  logic          nxt_rvalid;
  logic [31:0]   rdata_ff;
  logic [31:0]   nxt_rdata;
  logic [1:0]    rresp_ff;
  logic [1:0]    nxt_rresp;

  //----------------------------------------------------------------------------
  // Return stack
  //----------------------------------------------------------------------------
  pcseq_stack #(
    .DEPTH (STACK_DEPTH),
    .W     (pcseq_pkg::PC_W)
  ) u_stack (
    .core_clk   (core_clk),
    .reset_n    (reset_n),
    .push       (push),
    .pop        (pop),
    .push_data  (pc_ff + 12'h001),
    .top_data   (stack_top),
    .fill_level (stack_fill)
  );

  //----------------------------------------------------------------------------
  // Sequencer
  //----------------------------------------------------------------------------
  // Page select bits from the status register
  assign page_bits = {status_flags_reg[pcseq_pkg::PAGE_HIGH_BIT],
                      status_flags_reg[pcseq_pkg::PAGE_LOW_BIT]};

  // Stall state drops the command port for the extra branch cycle
  assign cmd_ready = (state_ff == PCSEQ_RUN);
  assign take = cmd_valid && cmd_ready;
  assign writes_pc = (cmd_op == pcseq_pkg::PCSEQ_OP_JUMP) ||
                     (cmd_op == pcseq_pkg::PCSEQ_OP_CALL) ||
                     (cmd_op == pcseq_pkg::PCSEQ_OP_RETURN) ||
                     (cmd_op == pcseq_pkg::PCSEQ_OP_ADD) ||
                     (cmd_op == pcseq_pkg::PCSEQ_OP_WRITE);
  assign push = take && (cmd_op == pcseq_pkg::PCSEQ_OP_CALL);
  assign pop  = take && (cmd_op == pcseq_pkg::PCSEQ_OP_RETURN);

  // Next counter value per command
  always_comb
  begin
    nxt_pc = pc_ff;
    nxt_state = state_ff;
    nxt_fetch_valid = 1'b1;
    case (state_ff)
      PCSEQ_RUN:
      begin
        if (take)
        begin
          case (cmd_op)
            pcseq_pkg::PCSEQ_OP_NEXT:
              nxt_pc = pc_ff + 12'h001;
            pcseq_pkg::PCSEQ_OP_JUMP:
              nxt_pc = {page_bits, cmd_target};
            pcseq_pkg::PCSEQ_OP_CALL:
              nxt_pc = {page_bits, cmd_target};
            pcseq_pkg::PCSEQ_OP_RETURN:
              nxt_pc = stack_top;
            pcseq_pkg::PCSEQ_OP_ADD:
              nxt_pc = pc_ff + {4'h0, cmd_data};
            pcseq_pkg::PCSEQ_OP_WRITE:
              nxt_pc = {page_bits, pc_ff[9:8], cmd_data};
            default:
              nxt_pc = pc_ff;
          endcase
          // Two-cycle option flushes the prefetched word
          if (writes_pc && branch_cycle_option_ff)
          begin
            nxt_state = PCSEQ_STALL;
            nxt_fetch_valid = 1'b0;
          end
        end
        else if (sw_pc_we)
        begin
          nxt_pc = sw_pc_val;
        end
      end
      PCSEQ_STALL:
      begin
        nxt_state = PCSEQ_RUN;
        // Software write still lands while the command port is stalled
        if (sw_pc_we)
          nxt_pc = sw_pc_val;
      end
      default:
      begin
        nxt_state = PCSEQ_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      pc_ff          <= pcseq_pkg::PC_RESET;
      state_ff       <= PCSEQ_RUN;
      fetch_valid_ff <= 1'b0;
    end
    else
    begin
      pc_ff          <= nxt_pc;
      state_ff       <= nxt_state;
      fetch_valid_ff <= nxt_fetch_valid;
    end
  end

  // Counter drives the fetch address directly
  assign fetch_addr  = pc_ff;
  assign fetch_valid = fetch_valid_ff;

  //----------------------------------------------------------------------------
  // AXI4-Lite write path
  //----------------------------------------------------------------------------
  assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
  assign s_axi_wready  = !w_hold_ff && !bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  // Decoder command wins over software in the same cycle
  assign sw_pc_we  = aw_hold_ff && w_hold_ff && !bvalid_ff &&
                     (aw_addr_ff == pcseq_pkg::ADDR_PC);
  assign sw_pc_val = {w_strb_ff[1] ? w_data_ff[11:8] : pc_ff[11:8],
                      w_strb_ff[0] ? w_data_ff[7:0] : pc_ff[7:0]};

  // Address and data latch in either order, response when both held
  always_comb
  begin
    nxt_aw_hold = aw_hold_ff;
    nxt_aw_addr = aw_addr_ff;
    nxt_w_hold  = w_hold_ff;
    nxt_w_data  = w_data_ff;
    nxt_w_strb  = w_strb_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    nxt_branch_cycle_option = branch_cycle_option_ff;
    if (s_axi_awvalid && s_axi_awready)
    begin
      nxt_aw_hold = 1'b1;
      nxt_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      nxt_w_hold = 1'b1;
      nxt_w_data = s_axi_wdata;
      nxt_w_strb = s_axi_wstrb;
    end
    if (aw_hold_ff && w_hold_ff && !bvalid_ff)
    begin
      // PC write waits while the decoder owns the counter this cycle
      if (!(sw_pc_we && take))
      begin
        nxt_bvalid  = 1'b1;
        nxt_aw_hold = 1'b0;
        nxt_w_hold  = 1'b0;
        nxt_bresp   = pcseq_pkg::RESP_OKAY;
        case (aw_addr_ff)
          pcseq_pkg::ADDR_PC:
            nxt_bresp = pcseq_pkg::RESP_OKAY;
          pcseq_pkg::ADDR_OPTION:
          begin
            if (w_strb_ff[0])
              nxt_branch_cycle_option = w_data_ff[0];
          end
          pcseq_pkg::ADDR_STATUS,
          pcseq_pkg::ADDR_DEPTH:
            nxt_bresp = pcseq_pkg::RESP_OKAY;
          default:
            nxt_bresp = pcseq_pkg::RESP_SLVERR;
        endcase
      end
    end
    if (bvalid_ff && s_axi_bready)
      nxt_bvalid = 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      aw_hold_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_hold_ff  <= 1'b0;
      w_data_ff  <= 32'h0000_0000;
      w_strb_ff  <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= pcseq_pkg::RESP_OKAY;
      branch_cycle_option_ff <= 1'b0;
    end
    else
    begin
      aw_hold_ff <= nxt_aw_hold;
      aw_addr_ff <= nxt_aw_addr;
      w_hold_ff  <= nxt_w_hold;
      w_data_ff  <= nxt_w_data;
      w_strb_ff  <= nxt_w_strb;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      branch_cycle_option_ff <= nxt_branch_cycle_option;
    end
  end

  //----------------------------------------------------------------------------
  // AXI4-Lite read path
  //----------------------------------------------------------------------------
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  // Read data captured on the same edge that takes the address, valid from the next cycle
  always_comb
  begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    if (s_axi_arvalid && s_axi_arready)
    begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = pcseq_pkg::RESP_OKAY;
      case (s_axi_araddr)
        pcseq_pkg::ADDR_PC:
          nxt_rdata = {20'h00000, pc_ff};
        pcseq_pkg::ADDR_STATUS:
          nxt_rdata = {22'h000000, ~cmd_ready, page_bits, stack_fill[6:0]};
        pcseq_pkg::ADDR_OPTION:
          nxt_rdata = {31'h00000000, branch_cycle_option_ff};
        pcseq_pkg::ADDR_DEPTH:
          nxt_rdata = {24'h000000, 8'(STACK_DEPTH)};
        default:
        begin
          nxt_rdata = 32'h0000_0000;
          nxt_rresp = pcseq_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_ff && s_axi_rready)
    begin
      nxt_rvalid = 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= pcseq_pkg::RESP_OKAY;
    end
    else
    begin
      rvalid_ff <= nxt_rvalid;
      rdata_ff  <= nxt_rdata;
      rresp_ff  <= nxt_rresp;
    end
  end

endmodule

`default_nettype wire

/* File: sim/pcseq_chk.sv */
// Concurrent checks on the sequencer's decoder and fetch ports.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module pcseq_chk (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        reset_n,
  // Decoder and status
  input wire logic        cmd_valid,
  input wire logic [2:0]  cmd_op,
  input wire logic [9:0]  cmd_target,
  input wire logic [7:0]  cmd_data,
  input wire logic        cmd_ready,
  input wire logic [7:0]  status_flags_reg,
  // Fetch
  input wire logic [11:0] fetch_addr,
  input wire logic        fetch_valid
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // Taken command, and whether it redirects the counter
  logic taken;
  logic redirect;
  assign taken    = cmd_valid && cmd_ready;
  assign redirect = taken && (cmd_op != 3'h0) && (cmd_op != 3'h6);

  sequence s_op(logic [2:0] op);
    taken && (cmd_op == op);
  endsequence
  sequence s_load;
    s_op(3'h1) or s_op(3'h2);
  endsequence

  property p_reset_zero;
    $rose(reset_n) |-> fetch_addr == 12'h000;
  endproperty
  property p_next;
    s_op(3'h0) |=> fetch_addr == $past(fetch_addr) + 12'h001;
  endproperty
  property p_load;
    s_load |=> fetch_addr == {$past(status_flags_reg[6:5]), $past(cmd_target)};
  endproperty
  // Back-to-back call and return lands just past the call
  property p_call_ret;
    s_op(3'h2) ##1 s_op(3'h3) |=> fetch_addr == $past(fetch_addr, 2) + 12'h001;
  endproperty
  property p_add;
    s_op(3'h4) |=> fetch_addr[9:0] == $past(fetch_addr[9:0]) + {2'h0, $past(cmd_data)};
  endproperty
  property p_write;
    s_op(3'h5) |=> fetch_addr == {$past(status_flags_reg[6:5]), $past(fetch_addr[9:8]),
                                  $past(cmd_data)};
  endproperty
  property p_stall_cause;
    !cmd_ready |-> $past(redirect) && !fetch_valid;
  endproperty
  property p_stall_once;
    !cmd_ready |=> cmd_ready;
  endproperty

  a_reset_zero: assert property (p_reset_zero) else $error("counter not zero");
  a_next: assert property (p_next) else $error("bad increment");
  a_load: assert property (p_load) else $error("bad jump or call target");
  a_call_ret: assert property (p_call_ret) else $error("bad return address");
  a_add: assert property (p_add) else $error("bad relative add");
  a_write: assert property (p_write) else $error("bad counter write");
  a_stall_cause: assert property (p_stall_cause) else $error("stray stall");
  a_stall_once: assert property (p_stall_once) else $error("stall too long");
endmodule

bind pcseq_top pcseq_chk i_chk (.core_clk, .reset_n, .cmd_valid, .cmd_op, .cmd_target,
  .cmd_data, .cmd_ready, .status_flags_reg, .fetch_addr, .fetch_valid);

`default_nettype wire

/* File: sim/pcseq_dec.sv */
// Decoder model that issues sequencing commands to the counter.
// Assumes its caller enters issue() just after a clock edge.
`timescale 1ns/1ps
`default_nettype none

module pcseq_dec (
  // Clock
  input  wire logic       core_clk,
  // Command
  output var  logic       cmd_valid,
  output var  logic [2:0] cmd_op,
  output var  logic [9:0] cmd_target,
  output var  logic [7:0] cmd_data,
  // Flow control
  input  wire logic       cmd_ready
);
  initial
  begin
    cmd_valid  = 1'b0;
    cmd_op     = 3'h6;
    cmd_target = 10'h2a5;
    cmd_data   = 8'h5a;
  end

  // Idle lines toggle so a stale command can never look valid
  task automatic issue(input logic [2:0] op, input logic [9:0] t, input logic [7:0] d,
                       input int gap);
    repeat (gap)
    begin
      cmd_target <= ~cmd_target;
      cmd_data   <= ~cmd_data;
      @(posedge core_clk);
    end
    cmd_valid  <= 1'b1;
    cmd_op     <= op;
    cmd_target <= t;
    cmd_data   <= d;
    do
      @(posedge core_clk);
    while (cmd_ready !== 1'b1);
    cmd_valid  <= 1'b0;
    cmd_op     <= ~op;
    cmd_target <= ~t;
    cmd_data   <= ~d;
  endtask
endmodule

`default_nettype wire

/* File: sim/tb_program_counter_sequencer.sv */
// Self-checking bench for the counter sequencer with a queue model.
// Assumes the checker is bound to the top and the decoder model drives commands.
`timescale 1ns/1ps
`default_nettype none

module tb_program_counter_sequencer;
  localparam int DEPTH = 4;
  logic        core_clk = 1'b0;
  logic        reset_n  = 1'b0;
  logic        cmd_valid, cmd_ready, fetch_valid;
  logic [2:0]  cmd_op, op;
  logic [9:0]  cmd_target;
  logic [7:0]  cmd_data, status_flags_reg, d;
  logic [11:0] fetch_addr, mpc;
  logic [11:0] stk[$];
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        opt;
  int          seed = 4484;
  int          bad_count = 0;
  int          samples_checked = 0;

  always #5 core_clk = ~core_clk;

  pcseq_top #(.STACK_DEPTH(DEPTH)) i_dut (.core_clk, .reset_n, .cmd_valid, .cmd_op,
    .cmd_target, .cmd_data, .cmd_ready, .status_flags_reg, .fetch_addr, .fetch_valid,
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp);

  pcseq_dec i_dec (.core_clk, .cmd_valid, .cmd_op, .cmd_target, .cmd_data, .cmd_ready);

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_wstrb   <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    while (s_axi_bvalid !== 1'b1)
      @(posedge core_clk);
    check(s_axi_bresp, r);
    s_axi_bready <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
      @(posedge core_clk);
    while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do
      @(posedge core_clk);
    while (s_axi_rvalid !== 1'b1);
    check(s_axi_rdata, v);
    check(s_axi_rresp, r);
    s_axi_rready <= 1'b0;
    @(posedge core_clk);
  endtask

  // One command through the decoder, then model and compare
  task automatic cmd(input logic [2:0] c, input logic [9:0] t, input logic [7:0] v,
                     input int gap);
    logic [7:0] st;
    st = 8'($random(seed));
    if (c == 3'h4)
      st[6:5] = mpc[11:10];
    status_flags_reg <= st;
    i_dec.issue(c, t, v, gap);
    case (c)
      3'h0: mpc = mpc + 12'h001;
      3'h1: mpc = {st[6:5], t};
      3'h2:
      begin
        stk.push_back(mpc + 12'h001);
        if (stk.size() > DEPTH)
          void'(stk.pop_front());
        mpc = {st[6:5], t};
      end
      3'h3: mpc = stk.pop_back();
      3'h4: mpc = mpc + {4'h0, v};
      3'h5: mpc = {st[6:5], mpc[9:8], v};
      default: ;
    endcase
    #1;
    check(fetch_addr, mpc);
    check({cmd_ready, fetch_valid}, (opt && c >= 3'h1 && c <= 3'h5) ? 2'h0 : 2'h3);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    status_flags_reg = 8'h00;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    opt = 1'b0;
    mpc = 12'h000;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    #1;
    check(fetch_addr, 12'h000);
    axi_rd(8'h00, 32'h0, 2'h0);
    axi_rd(8'h0c, DEPTH, 2'h0);
    axi_rd(8'h10, 32'h0, 2'h2);
    axi_wr(8'h14, 32'h1, 2'h2);
    axi_wr(8'h00, 32'h123, 2'h0);
    mpc = 12'h123;
    axi_rd(8'h00, 32'h123, 2'h0);
    for (int o = 0; o < 2; o++)
    begin
      opt = o[0];
      axi_wr(8'h08, {31'h0, opt}, 2'h0);
      cmd(3'h1, 10'h0f0, 8'h00, 0);
      cmd(3'h4, 10'h000, 8'h20, 0);
      cmd(3'h5, 10'h000, 8'h5a, 0);
      // Overflow drops the oldest return address
      repeat (DEPTH + 1) cmd(3'h2, 10'($random(seed)), 8'h00, 0);
      repeat (DEPTH) cmd(3'h3, 10'h000, 8'h00, 0);
      repeat (40)
      begin
        op = 3'($unsigned($random(seed)) % 7);
        d  = 8'($random(seed));
        if (op == 3'h3 && stk.size() == 0)
          op = 3'h2;
        if (op == 3'h4 && {2'h0, mpc[9:0]} + {4'h0, d} > 12'h3ff)
          op = 3'h0;
        cmd(op, 10'($random(seed)), d, $unsigned($random(seed)) % 3);
      end
      axi_rd(8'h00, {20'h0, mpc}, 2'h0);
      axi_rd(8'h04, {22'h0, 1'b0, status_flags_reg[6:5], 7'(stk.size())}, 2'h0);
      axi_rd(8'h08, {31'h0, opt}, 2'h0);
    end
    tally_and_finish();
  end

  // Hang guard, far beyond the few hundred cycles the run needs
  initial
  begin
    repeat (5000) @(posedge core_clk);
    bad_count++;
    tally_and_finish();
  end
endmodule

`default_nettype wire
